// *** hw/epi_top.sv ***
// External pin request logic, source qualification and vector selection
`timescale 1ns/1ps
`default_nettype none
module epi_top
  import epi_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // External pin
  input wire logic I_PIN,
  output logic O_PULL_EN,
  output logic O_PULL_UP,
  output logic O_PIN_LEVEL,
  // Other sources and core handshake
  input wire logic [NUM_VEC-1:0] I_SRC_EVENT,
  input wire logic I_RESET_CAUSE,
  input wire logic I_GLOBAL_MASK,
  output logic O_IRQ_REQ,
  output logic O_RESET_REQ,
  output logic [4:0] O_VEC_NUM,
  output logic [15:0] O_VEC_ADDR_HI,
  output logic [15:0] O_VEC_ADDR_LO,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import epi_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;
    logic pin_prev;
    logic pin_asserted;
    logic pull_disable;
    logic edge_pol;
    logic pin_enable;
    logic pin_flag;
    logic irq_enable;
    logic mode_level;
    logic [NUM_VEC-1:0] src_flag;
    logic [NUM_VEC-1:0] src_en;
    logic aw_held;
    logic w_held;
    epi_wr_s wr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pull_en;
    logic pull_up;
    logic pin_level;
    logic irq_req;
    logic reset_req;
    logic [4:0] vec_num;
    logic [15:0] vec_hi;
    logic [15:0] vec_lo;
  } epi_state_s;

  epi_state_s s_q;
  epi_state_s s_d;

  // Address of the high byte for a vector number
  function automatic logic [15:0] vec_addr(input logic [4:0] n);
    vec_addr = VEC_TOP_ADDR - {10'h000, n, 1'b0};
  endfunction : vec_addr

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  // Mask of vectors that have a hardware source
  function automatic logic [NUM_VEC-1:0] used_mask();
    used_mask = '0;
    for (int i = 0; i <= LOWEST_USED_VEC; i++) begin
      used_mask[i] = 1'b1;
    end
  endfunction : used_mask

  logic [31:0] ctrl_rd;
  logic [NUM_VEC-1:0] pending;
  logic [31:0] wval;
  logic asserted_now;
  logic do_write;

  // Control register read view; ack always reads zero
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[PULL_DIS_BIT] = s_q.pull_disable;
    ctrl_rd[EDGE_POL_BIT] = s_q.edge_pol;
    ctrl_rd[PIN_EN_BIT] = s_q.pin_enable;
    ctrl_rd[FLAG_BIT] = s_q.pin_flag;
    ctrl_rd[ACK_BIT] = 1'b0;
    ctrl_rd[IRQ_EN_BIT] = s_q.irq_enable;
    ctrl_rd[MODE_BIT] = s_q.mode_level;
  end

  // Next state
  always_comb begin
    s_d = s_q;
    wval = '0;
    do_write = 1'b0;
    // Two-stage synchroniser; only the last stage is judged
    s_d.sync = {s_q.sync[SYNC_STAGES-2:0], I_PIN};
    s_d.pin_prev = s_q.sync[SYNC_STAGES-1];
    // Polarity zero means low is asserted
    asserted_now = s_q.edge_pol ? s_q.sync[SYNC_STAGES-1] : ~s_q.sync[SYNC_STAGES-1];
    s_d.pin_asserted = asserted_now;

    // AXI write channels accepted in either order
    if (AWVALID && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.wr.addr = AWADDR;
    end
    if (WVALID && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.wr.data = WDATA;
      s_d.wr.strb = WSTRB;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      do_write = 1'b1;
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end

    // Flag clear first, so a same-cycle event below wins
    if (do_write) begin
      unique case (s_q.wr.addr)
        REG_PIN_CTRL_OFS: begin
          wval = merge(ctrl_rd, s_q.wr.data, s_q.wr.strb);
          s_d.pull_disable = wval[PULL_DIS_BIT];
          s_d.edge_pol = wval[EDGE_POL_BIT];
          s_d.pin_enable = wval[PIN_EN_BIT];
          s_d.irq_enable = wval[IRQ_EN_BIT];
          s_d.mode_level = wval[MODE_BIT];
          if (wval[ACK_BIT]) begin
            s_d.pin_flag = 1'b0;
          end
          // Turning the pin function on raises the flag
          if (wval[PIN_EN_BIT] && !s_q.pin_enable) begin
            s_d.pin_flag = 1'b1;
          end
        end
        REG_SRC_FLAG_OFS: begin
          // Write one to clear a source flag
          s_d.src_flag = s_q.src_flag & ~(s_q.wr.data & {{8{s_q.wr.strb[3]}}, {8{s_q.wr.strb[2]}},
                                                         {8{s_q.wr.strb[1]}}, {8{s_q.wr.strb[0]}}});
        end
        REG_SRC_EN_OFS: begin
          s_d.src_en = merge(s_q.src_en, s_q.wr.data, s_q.wr.strb) & used_mask();
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Pin event detection on the synchronised level
    if (s_q.pin_enable) begin
      if (asserted_now && !s_q.pin_asserted) begin
        s_d.pin_flag = 1'b1;
      end
      if (s_q.mode_level && asserted_now) begin
        s_d.pin_flag = 1'b1;
      end
    end

    // Other sources set their sticky flags; set beats clear
    s_d.src_flag = (s_d.src_flag | I_SRC_EVENT) & used_mask();

    // AXI read
    if (ARVALID && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (ARADDR)
        REG_PIN_CTRL_OFS: s_d.rdata = ctrl_rd;
        REG_SRC_FLAG_OFS: s_d.rdata = s_q.src_flag;
        REG_SRC_EN_OFS: s_d.rdata = s_q.src_en;
        REG_VECTOR_OFS: s_d.rdata = {s_q.vec_lo, s_q.vec_hi};
        REG_STATUS_OFS: s_d.rdata = {24'h000000, s_q.irq_req, s_q.vec_num, s_q.pin_level, s_q.pin_asserted};
        default: begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end

    // Pull device: on when enabled unless disabled, direction by polarity
    s_d.pull_en = s_q.pin_enable && !s_q.pull_disable;
    s_d.pull_up = ~s_q.edge_pol;
    // Level for the branch instructions, only in pin mode
    s_d.pin_level = s_q.pin_enable & s_q.sync[SYNC_STAGES-1];

    // Qualified pending set: pin uses its own flag and enable
    pending = s_q.src_flag & s_q.src_en;
    pending[PIN_VEC] = s_q.pin_flag & s_q.irq_enable;
    pending[RESET_VEC] = I_RESET_CAUSE;
    pending[SWI_VEC] = s_q.src_flag[SWI_VEC]; // no local enable

    // Lowest number wins; scan from the bottom of priority upward
    s_d.vec_num = 5'h00;
    s_d.irq_req = 1'b0;
    for (int i = LOWEST_USED_VEC; i >= 0; i--) begin
      if (pending[i]) begin
        s_d.vec_num = 5'(i);
        s_d.irq_req = 1'b1;
      end
    end
    // Maskable requests reach the core only with the mask clear
    s_d.irq_req = s_d.irq_req & (!I_GLOBAL_MASK | I_RESET_CAUSE);
    s_d.reset_req = I_RESET_CAUSE;
    s_d.vec_hi = vec_addr(s_d.vec_num);
    s_d.vec_lo = vec_addr(s_d.vec_num) + 16'h0001;
  end

  // State register
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      s_q <= '0;
      s_q.pull_up <= 1'b1;
      s_q.vec_hi <= VEC_TOP_ADDR;
      s_q.vec_lo <= VEC_TOP_ADDR + 16'h0001;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign O_PULL_EN = s_q.pull_en;
  assign O_PULL_UP = s_q.pull_up;
  assign O_PIN_LEVEL = s_q.pin_level;
  assign O_IRQ_REQ = s_q.irq_req;
  assign O_RESET_REQ = s_q.reset_req;
  assign O_VEC_NUM = s_q.vec_num;
  assign O_VEC_ADDR_HI = s_q.vec_hi;
  assign O_VEC_ADDR_LO = s_q.vec_lo;
  assign AWREADY = ~s_q.aw_held;
  assign WREADY = ~s_q.w_held;
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign ARREADY = ~s_q.rvalid;
  assign RVALID = s_q.rvalid;
  assign RDATA = s_q.rdata;
  assign RRESP = s_q.rresp;

endmodule : epi_top
`default_nettype wire

// *** inc/epi_pkg.sv ***
// Package for the external pin request and vector logic
package epi_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_PIN_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_SRC_FLAG_OFS = 8'h04;
  localparam logic [7:0] REG_SRC_EN_OFS = 8'h08;
  localparam logic [7:0] REG_VECTOR_OFS = 8'h0c;
  localparam logic [7:0] REG_STATUS_OFS = 8'h10;

  // Control and status register field positions
  localparam int PULL_DIS_BIT = 6;
  localparam int EDGE_POL_BIT = 5;
  localparam int PIN_EN_BIT = 4;
  localparam int FLAG_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int IRQ_EN_BIT = 1;
  localparam int MODE_BIT = 0;

  // Reset values
  localparam logic [31:0] PIN_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SRC_EN_RST = 32'h0000_0000;

  // Vector table layout
  localparam int NUM_VEC = 32;
  localparam int LOWEST_USED_VEC = 22;
  localparam int PIN_VEC = 2;
  localparam int SWI_VEC = 1;
  localparam int LVW_VEC = 3;
  localparam int RESET_VEC = 0;
  localparam logic [15:0] VEC_TOP_ADDR = 16'hfffe;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write channel payload
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } epi_wr_s;

endpackage : epi_pkg

// *** verif/epi_core_model.sv ***
// Behavioural core that takes requests
`timescale 1ns/1ps
`default_nettype none
module epi_core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Request side
  input wire logic i_irq_req,
  input wire logic [4:0] i_vec_num,
  input wire logic i_unmask,
  output logic o_mask,
  output logic o_took,
  output logic [4:0] o_vec_taken
);
  // Mask set after reset; taking a request masks again
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_mask <= 1'b1;
      o_took <= 1'b0;
      o_vec_taken <= 5'h00;
    end else if (i_irq_req && !o_mask) begin
      o_mask <= 1'b1;
      o_took <= 1'b1;
      o_vec_taken <= i_vec_num;
    end else if (i_unmask) begin
      o_mask <= 1'b0;
      o_took <= 1'b0;
    end
  end
endmodule : epi_core_model
`default_nettype wire

// *** verif/epi_top_assertions.sv ***
// Port checks for the pin request and vector block
`timescale 1ns/1ps
`default_nettype none
module epi_assert (
  // Clock, reset and pin
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_PIN,
  input wire logic O_PIN_LEVEL,
  // Core side
  input wire logic I_RESET_CAUSE,
  input wire logic I_GLOBAL_MASK,
  input wire logic O_IRQ_REQ,
  input wire logic O_RESET_REQ,
  input wire logic [4:0] O_VEC_NUM,
  input wire logic [15:0] O_VEC_ADDR_HI,
  input wire logic [15:0] O_VEC_ADDR_LO,
  // Read channel
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  a_vec_lo_pair: assert property (O_VEC_ADDR_LO == O_VEC_ADDR_HI + 16'h0001)
    else $error("vec lo");
  a_vec_hi_addr: assert property (O_VEC_ADDR_HI == 16'hfffe - {10'h000, O_VEC_NUM, 1'b0})
    else $error("vec hi");
  a_mask_blocks: assert property (I_GLOBAL_MASK && !I_RESET_CAUSE |=> !O_IRQ_REQ)
    else $error("masked req");
  a_reset_vector: assert property (I_RESET_CAUSE |=> O_RESET_REQ && O_IRQ_REQ && O_VEC_NUM == 5'h00)
    else $error("reset vec");
  a_no_unused: assert property (O_IRQ_REQ |-> O_VEC_NUM <= 5'h16)
    else $error("unused vec");
  a_pin_synced: assert property ($rose(O_PIN_LEVEL) |-> $past(I_PIN, 3))
    else $error("pin sync");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read late");
  a_read_busy: assert property (RVALID |-> !ARREADY)
    else $error("ar busy");
endmodule : epi_assert
bind epi_top epi_assert i_chk (.I_CLK, .I_RESETN, .I_PIN, .O_PIN_LEVEL, .I_RESET_CAUSE, .I_GLOBAL_MASK,
  .O_IRQ_REQ, .O_RESET_REQ, .O_VEC_NUM, .O_VEC_ADDR_HI, .O_VEC_ADDR_LO, .ARVALID, .ARREADY, .RVALID);
`default_nettype wire

// *** verif/ext_pin_irq_and_vectors_tb_top.sv ***
// Self-checking bench for the pin request and vector block
`timescale 1ns/1ps
`default_nettype none
module ext_pin_irq_and_vectors_tb_top;
  import epi_pkg::*;
  // Counted compare
  `define C(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
  localparam logic [7:0] CS = REG_PIN_CTRL_OFS;
  int num_errors = 0;
  int n_compared = 0;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pin = 1'b1;
  logic cause = 1'b0;
  logic um = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] src = 32'h0;
  logic [31:0] rq;
  logic [1:0] rs;
  wire logic pen, pup, plv, irq, rrq, awr, wrr, bv, arr, rv, msk, took;
  wire logic [4:0] vn, vt;
  wire logic [15:0] vh, vl;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdt;
  always #12.5 clk = ~clk;
  epi_top i_dut (.I_CLK(clk), .I_RESETN(rstn), .I_PIN(pin), .O_PULL_EN(pen), .O_PULL_UP(pup),
    .O_PIN_LEVEL(plv), .I_SRC_EVENT(src), .I_RESET_CAUSE(cause), .I_GLOBAL_MASK(msk), .O_IRQ_REQ(irq),
    .O_RESET_REQ(rrq), .O_VEC_NUM(vn), .O_VEC_ADDR_HI(vh), .O_VEC_ADDR_LO(vl), .AWADDR(awa),
    .AWVALID(awv), .AWREADY(awr), .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrr), .BRESP(br),
    .BVALID(bv), .BREADY(1'b1), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rdt), .RRESP(rr),
    .RVALID(rv), .RREADY(1'b1));
  epi_core_model i_core (.i_clk(clk), .i_resetn(rstn), .i_irq_req(irq), .i_vec_num(vn), .i_unmask(um),
    .o_mask(msk), .o_took(took), .o_vec_taken(vt));
  // Bus write; readies read mid-cycle, which is what the next rising edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic got;
    logic aw_take;
    logic w_take;
    got = 1'b0;
    aw_take = 1'b0;
    w_take = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!got) begin
      @(negedge clk);
      aw_take = awr;
      w_take = wrr;
      got = bv;
      rs = br;
      @(posedge clk);
      if (aw_take) awv <= 1'b0;
      if (w_take) wv <= 1'b0;
    end
  endtask : wr
  // Bus read
  task automatic rd(input logic [7:0] a);
    logic got;
    logic ar_take;
    got = 1'b0;
    ar_take = 1'b0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    while (!got) begin
      @(negedge clk);
      ar_take = arr;
      got = rv;
      rq = rdt;
      rs = rr;
      @(posedge clk);
      if (ar_take) arv <= 1'b0;
    end
  endtask : rd
  // Helpers
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic sp(input logic v);
    @(posedge clk);
    pin <= v;
  endtask : sp
  task automatic unm;
    @(posedge clk);
    um <= 1'b1;
    @(posedge clk);
    um <= 1'b0;
  endtask : unm
  task automatic ev(input logic [31:0] b);
    @(posedge clk);
    src <= b;
    @(posedge clk);
    src <= 32'h0;
  endtask : ev
  // Register defaults, refusals, disabled pin
  task automatic t_regs;
    rd(CS);
    `C("ctrl", PIN_CTRL_RST, rq)
    rd(8'h14);
    `C("unmapped", {RESP_SLVERR, 32'h0}, {rs, rq})
    wr(REG_VECTOR_OFS, 32'h0);
    `C("ro resp", RESP_SLVERR, rs)
    sp(1'b0);
    wt(8);
    rd(CS);
    `C("flag", 1'b0, rq[FLAG_BIT])
    `C("level", 1'b0, plv)
    sp(1'b1);
    $display("regs done");
  endtask : t_regs
  // Enable, pull device, ack
  task automatic t_pin;
    wr(CS, 32'h10);
    wt(6);
    rd(CS);
    `C("flag", 1'b1, rq[FLAG_BIT])
    `C("pull", 2'h3, {pen, pup})
    `C("level", 1'b1, plv)
    wr(CS, 32'h14);
    rd(CS);
    `C("ack", 32'h10, rq)
    wr(CS, 32'h50);
    wt(2);
    `C("pull", 1'b0, pen)
    wr(CS, 32'h30);
    wt(2);
    `C("pulldown", 1'b0, pup)
    $display("pin done");
  endtask : t_pin
  // Falling edge, polling, then request
  task automatic t_edge;
    wr(CS, 32'h14);
    wt(4);
    sp(1'b0);
    wt(8);
    rd(CS);
    `C("flag", 1'b1, rq[FLAG_BIT])
    `C("level", 1'b0, plv)
    unm;
    wt(4);
    `C("polled", 1'b0, took)
    wr(CS, 32'h12);
    wt(4);
    `C("taken", {1'b1, 5'(PIN_VEC)}, {took, vt})
    `C("vector", 32'hfffafffb, {vh, vl})
    wr(CS, 32'h16);
    rd(CS);
    `C("ack", 1'b0, rq[FLAG_BIT])
    sp(1'b1);
    $display("edge done");
  endtask : t_edge
  // Level mode keeps flag while asserted
  task automatic t_level;
    wr(CS, 32'h15);
    sp(1'b0);
    wt(8);
    wr(CS, 32'h15);
    rd(CS);
    `C("hold", 1'b1, rq[FLAG_BIT])
    sp(1'b1);
    wt(8);
    wr(CS, 32'h15);
    rd(CS);
    `C("free", 1'b0, rq[FLAG_BIT])
    $display("level done");
  endtask : t_level
  // Priority, local enables, reset vector
  task automatic t_prio;
    wr(CS, 32'h0);
    wr(REG_SRC_EN_OFS, 32'h02000208);
    ev(32'h02000288);
    wt(4);
    `C("top", {5'(LVW_VEC), 16'hfff8}, {vn, vh})
    unm;
    wt(4);
    `C("taken", 5'(LVW_VEC), vt)
    wr(REG_SRC_FLAG_OFS, 32'h8);
    wt(4);
    `C("next", 5'h09, vn)
    wr(REG_SRC_FLAG_OFS, 32'h288);
    ev(32'h2);
    wt(4);
    `C("swi", 16'hfffc, vh)
    @(posedge clk);
    cause <= 1'b1;
    wt(3);
    `C("reset", {1'b1, 16'hfffe}, {rrq, vh})
    cause <= 1'b0;
    $display("prio done");
  endtask : t_prio
  // Verdict
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_pin;
    t_edge;
    t_level;
    t_prio;
    conclude;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude;
  end
endmodule : ext_pin_irq_and_vectors_tb_top
`default_nettype wire
